// file: taf_pkg.sv
// constants shared by the limit-flag bank and its comparator
package taf_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_FLAGS_LO   = 10'h017; // flags for channels 8 to 11
  localparam logic [9:0] IDX_FLAGS_HI   = 10'h018; // flags for channels 12 to 15
  localparam logic [9:0] IDX_SETUP      = 10'h020; // setup word, alert mode only
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         SETUP_MODE_BIT = 7;       // alert mode select position
  localparam logic [7:0] FLAGS_RESET    = 8'h00;   // both flag words after reset
  localparam logic       MODE_RESET     = 1'b0;    // alert mode after reset
  localparam int         RESULT_W       = 16;      // conversion result width
  localparam int         ADDR_W         = 12;      // axi address width
  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY      = 2'h0;    // access accepted
  localparam logic [1:0] RESP_SLVERR    = 2'h2;    // unmapped address
endpackage : taf_pkg

// file: taf_cmp_if.sv
// bundle between the flag bank and the limit comparator
`timescale 1ns/1ps
interface taf_cmp_if;
  import taf_pkg::*;
  logic [RESULT_W-1:0] result;    // conversion result under test
  logic [RESULT_W-1:0] upper;     // upper limit of that channel
  logic [RESULT_W-1:0] lower;     // lower limit of that channel
  logic [RESULT_W-1:0] band;      // hysteresis width of that channel
  logic                over_hit;  // result at or above upper
  logic                under_hit; // result at or below lower
  logic                over_back; // result back below upper minus band
  logic                under_back; // result back above lower plus band
  modport cmp  (input result, upper, lower, band,
                output over_hit, under_hit, over_back, under_back);
  modport user (output result, upper, lower, band,
                input over_hit, under_hit, over_back, under_back);
endinterface : taf_cmp_if

// file: taf_limit_cmp.sv
// limit and hysteresis comparator for one conversion result
`timescale 1ns/1ps
module taf_limit_cmp
  import taf_pkg::*;
(
  taf_cmp_if.cmp cmp_bus // result, limits and verdicts
);
  // sums carry one extra bit so a wide band never wraps round
  logic [RESULT_W:0] upper_gap; // result plus band
  logic [RESULT_W:0] lower_gap; // lower plus band

  // ----------------------------------------------------------------
  // threshold tests
  // ----------------------------------------------------------------
  assign upper_gap          = {1'b0, cmp_bus.result} + {1'b0, cmp_bus.band};
  assign lower_gap          = {1'b0, cmp_bus.lower} + {1'b0, cmp_bus.band};
  assign cmp_bus.over_hit   = cmp_bus.result >= cmp_bus.upper;
  assign cmp_bus.under_hit  = cmp_bus.result <= cmp_bus.lower;
  // inside the band means clear of the limit by more than the band
  assign cmp_bus.over_back  = upper_gap < {1'b0, cmp_bus.upper};
  assign cmp_bus.under_back = {1'b0, cmp_bus.result} > lower_gap;
endmodule : taf_limit_cmp

// file: taf_alert_flags.sv
// sticky over/under limit flags for channels 8 to 15 behind axi4-lite
`timescale 1ns/1ps
module taf_alert_flags
  import taf_pkg::*;
(
  input  wire logic                aclk,          // 10 mhz system clock
  input  wire logic                aresetn,       // synchronous reset, low active
  input  wire logic                res_valid,     // one-cycle result strobe
  input  wire logic [3:0]          res_chan,      // channel of the result
  input  wire logic [RESULT_W-1:0] res_data,      // corrected conversion result
  input  wire logic [RESULT_W-1:0] upper_limit,   // upper limit of res_chan
  input  wire logic [RESULT_W-1:0] lower_limit,   // lower limit of res_chan
  input  wire logic [RESULT_W-1:0] band_setting,  // hysteresis of res_chan
  input  wire logic [7:0]          detect_en,     // detection enable, ch8 at bit 0
  input  wire logic [ADDR_W-1:0]   s_awaddr,      // write address
  input  wire logic                s_awvalid,     // write address valid
  output logic                     s_awready,     // write address ready
  input  wire logic [31:0]         s_wdata,       // write data
  input  wire logic [3:0]          s_wstrb,       // write byte enables
  input  wire logic                s_wvalid,      // write data valid
  output logic                     s_wready,      // write data ready
  output logic [1:0]               s_bresp,       // write response
  output logic                     s_bvalid,      // write response valid
  input  wire logic                s_bready,      // write response ready
  input  wire logic [ADDR_W-1:0]   s_araddr,      // read address
  input  wire logic                s_arvalid,     // read address valid
  output logic                     s_arready,     // read address ready
  output logic [31:0]              s_rdata,       // read data
  output logic [1:0]               s_rresp,       // read response
  output logic                     s_rvalid,      // read data valid
  input  wire logic                s_rready,      // read data ready
  output logic                     alert_mode,    // auto clear inside band
  output logic [15:0]              limit_flags    // ch12-15 high, ch8-11 low
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2]; // byte address to word index
  endfunction : word_index

  taf_cmp_if       cmp_bus ();      // comparator bundle
  logic [15:0]     next_flags;      // flag values at the next edge
  logic            aw_held;         // write address captured
  logic            w_held;          // write data captured
  logic [9:0]      aw_idx;          // captured write index
  logic [31:0]     w_data;          // captured write data
  logic            w_lane0;         // captured low byte enable
  logic            rd_take;         // read address taken this cycle
  logic [9:0]      rd_idx;          // index of the read being taken
  logic            clr_lo;          // read clears channels 8 to 11
  logic            clr_hi;          // read clears channels 12 to 15
  logic            ch_upper;        // result belongs to channels 8 to 15

  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  assign cmp_bus.result = res_data;
  assign cmp_bus.upper  = upper_limit;
  assign cmp_bus.lower  = lower_limit;
  assign cmp_bus.band   = band_setting;

  taf_limit_cmp i_taf_limit_cmp (
    .cmp_bus (cmp_bus)
  );

  // ----------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------
  assign ch_upper = res_valid && res_chan[3];
  assign rd_take  = s_arvalid && s_arready;
  assign rd_idx   = word_index(s_araddr);
  assign clr_lo   = rd_take && (rd_idx == IDX_FLAGS_LO);
  assign clr_hi   = rd_take && (rd_idx == IDX_FLAGS_HI);

  // two bits per channel: over at even, under at odd position
  always_comb begin
    logic sel;
    logic rd_clr;
    sel        = 1'b0;
    rd_clr     = 1'b0;
    next_flags = limit_flags;
    for (int j = 0; j < 8; j++) begin
      // only the channel just converted is touched by the result; a read clears all four channels of its word
      sel    = ch_upper && (res_chan[2:0] == 3'(j));
      rd_clr = (j < 4) ? clr_lo : clr_hi;
      // set term is or-ed last so it survives a read clear
      next_flags[2*j] = (limit_flags[2*j] && !rd_clr
                         && !(sel && alert_mode && cmp_bus.over_back))
                        || (sel && detect_en[j] && cmp_bus.over_hit);
      next_flags[2*j+1] = (limit_flags[2*j+1] && !rd_clr
                           && !(sel && alert_mode && cmp_bus.under_back))
                          || (sel && detect_en[j] && cmp_bus.under_hit);
    end
  end

  // flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_flags <= {FLAGS_RESET, FLAGS_RESET};
    end else begin
      limit_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // one write at a time: both halves are refused until the answer goes
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 10'h000;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0; // consumed into the response
      w_held  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= word_index(s_awaddr);
      end
      if (s_wvalid && s_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_wdata;
        w_lane0 <= s_wstrb[0];
      end
    end
  end

  // response and setup register; flag words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid   <= 1'b0;
      s_bresp    <= RESP_OKAY;
      alert_mode <= MODE_RESET;
    end else if (aw_held && w_held) begin
      s_bvalid <= 1'b1;
      if (aw_idx == IDX_SETUP) begin
        s_bresp <= RESP_OKAY;
        if (w_lane0) begin
          alert_mode <= w_data[SETUP_MODE_BIT];
        end
      end else if (aw_idx == IDX_FLAGS_LO || aw_idx == IDX_FLAGS_HI) begin
        s_bresp <= RESP_OKAY; // read-only, data dropped
      end else begin
        s_bresp <= RESP_SLVERR;
      end
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_arready = !s_rvalid;

  // data are captured from the flags as they stand before the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_rvalid <= 1'b1;
      s_rresp  <= RESP_OKAY;
      if (rd_idx == IDX_FLAGS_LO) begin
        s_rdata <= {24'h00_0000, limit_flags[7:0]};
      end else if (rd_idx == IDX_FLAGS_HI) begin
        s_rdata <= {24'h00_0000, limit_flags[15:8]};
      end else if (rd_idx == IDX_SETUP) begin
        s_rdata <= {24'h00_0000, alert_mode, 7'h00};
      end else begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= RESP_SLVERR;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  over_set_a: assert property (
    res_valid && res_chan == 4'h8 && detect_en[0] && res_data >= upper_limit
    |=> limit_flags[0])
    else $error("ch8 over flag not set");

  under_set_a: assert property (
    res_valid && res_chan == 4'hf && detect_en[7] && res_data <= lower_limit
    |=> limit_flags[15])
    else $error("ch15 under flag not set");

  enable_gate_a: assert property (
    $rose(limit_flags[1]) |-> $past(detect_en[0]) && $past(res_valid))
    else $error("flag set with detection off");

  flag_hold_a: assert property (
    limit_flags[2] && !clr_lo && !(res_valid && res_chan == 4'h9 && alert_mode)
    |=> limit_flags[2])
    else $error("ch9 over flag lost without clear");

  band_clear_a: assert property (
    alert_mode && res_valid && res_chan == 4'h9
    && 17'(res_data) + 17'(band_setting) < 17'(upper_limit)
    |=> !limit_flags[2])
    else $error("ch9 over flag not cleared in band");

  lo_read_a: assert property (
    clr_lo && !res_valid |=> s_rvalid && s_rdata[7:0] == $past(limit_flags[7:0])
    && limit_flags[7:0] == 8'h00 && s_rdata[31:8] == 24'h00_0000)
    else $error("low flag word read wrong");

  hi_read_a: assert property (
    clr_hi && !res_valid |=> s_rvalid && s_rdata[7:0] == $past(limit_flags[15:8])
    ##1 limit_flags[15:8] == 8'h00 || $past(res_valid))
    else $error("high flag word read wrong");

  reset_zero_a: assert property (disable iff (1'b0)
    !aresetn |=> limit_flags == 16'h0000 && !alert_mode)
    else $error("flags not zero after reset");

  set_wins_a: assert property (
    clr_hi && res_valid && res_chan == 4'hc && detect_en[4]
    && res_data >= upper_limit |=> limit_flags[8])
    else $error("set lost to read clear");

  other_chan_a: assert property (
    !(res_valid && res_chan == 4'h9) && !clr_lo |=> $stable(limit_flags[3:2]))
    else $error("ch9 flags changed for other channel");
endmodule : taf_alert_flags

// file: taf_alert_flags_bench.sv
// self-checking bench for the channel 8 to 15 limit-flag bank
`timescale 1ns/1ps
module taf_alert_flags_bench;
  import taf_pkg::*;
  // one compare: counts it, reports a mismatch at once
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                aclk = 1'b0;         // 100 ns bench clock
  logic                aresetn = 1'b0;      // held low for 3 cycles
  logic                res_valid = 1'b0;    // result strobe
  logic [3:0]          res_chan = 4'h0;     // result channel
  logic [RESULT_W-1:0] res_data = '0;       // result value
  logic [RESULT_W-1:0] upper_limit = '0;    // upper limit
  logic [RESULT_W-1:0] lower_limit = '0;    // lower limit
  logic [RESULT_W-1:0] band_setting = '0;   // hysteresis width
  logic [7:0]          detect_en = 8'h00;   // per-channel enables
  logic [ADDR_W-1:0]   s_awaddr = '0;       // write address
  logic [ADDR_W-1:0]   s_araddr = '0;       // read address
  logic [31:0]         s_wdata = '0;        // write data
  logic [3:0]          s_wstrb = 4'hf;      // whole word always
  logic                s_awvalid = 1'b0;    // aw valid
  logic                s_wvalid = 1'b0;     // w valid
  logic                s_bready = 1'b0;     // b ready
  logic                s_arvalid = 1'b0;    // ar valid
  logic                s_rready = 1'b0;     // r ready
  logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid; // slave handshakes
  logic [1:0]          s_bresp, s_rresp;    // responses
  logic [31:0]         s_rdata;             // read data
  logic                alert_mode;          // auto clear select
  logic [15:0]         limit_flags;         // all sixteen flags
  int                  failures = 0;        // mismatch count
  int                  samples_checked = 0; // compare count
  int                  cycles = 0;          // hang guard
  localparam logic [ADDR_W-1:0] A_LO = {IDX_FLAGS_LO, 2'b00}; // byte address, ch8-11
  localparam logic [ADDR_W-1:0] A_HI = {IDX_FLAGS_HI, 2'b00}; // byte address, ch12-15
  localparam logic [ADDR_W-1:0] A_SU = {IDX_SETUP, 2'b00};    // byte address, setup
  taf_alert_flags i_taf_alert_flags (.aclk, .aresetn, .res_valid, .res_chan, .res_data,
    .upper_limit, .lower_limit, .band_setting, .detect_en, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .alert_mode, .limit_flags);
  // free-running clock
  always #50 aclk = ~aclk;
  // run is about 140 cycles; the ceiling leaves ample slack
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // tasks: entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // readies are sampled at the falling edge, where they have settled
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hit = s_awvalid & s_awready;
      w_hit = s_wvalid & s_wready;
      @(posedge aclk);
      if (aw_hit) s_awvalid <= 1'b0;
      if (w_hit) s_wvalid <= 1'b0;
    end while ((s_awvalid & !aw_hit) | (s_wvalid & !w_hit));
    do begin
      @(negedge aclk);
      b_hit = s_bvalid;
      resp = s_bresp;
      @(posedge aclk);
    end while (b_hit !== 1'b1);
    s_bready <= 1'b0;
    @(posedge aclk); // idle edge: a next call never re-drives bready in this step
    `CHK(resp, er)
  endtask : axi_wr
  // also ends a result strobe raised for the same edge as the address
  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hit;
    logic [31:0] data;
    logic [1:0] resp;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge aclk);
      hit = s_arready;
      @(posedge aclk);
    end while (hit !== 1'b1);
    s_arvalid <= 1'b0;
    res_valid <= 1'b0;
    do begin
      @(negedge aclk);
      hit = s_rvalid;
      data = s_rdata;
      resp = s_rresp;
      @(posedge aclk);
    end while (hit !== 1'b1);
    s_rready <= 1'b0;
    @(posedge aclk); // idle edge: a next call never re-drives rready in this step
    `CHK(data, ed)
    `CHK(resp, er)
  endtask : axi_rd
  // one result pulse with its channel's limits, then one idle cycle
  task automatic conv(input logic [3:0] c, input logic [15:0] d, up, lo, bd);
    res_chan <= c;
    res_data <= d;
    upper_limit <= up;
    lower_limit <= lo;
    band_setting <= bd;
    res_valid <= 1'b1;
    @(posedge aclk);
    res_valid <= 1'b0;
    @(posedge aclk); // strobe drops for an edge between back-to-back calls
  endtask : conv
  // flags stand until read, so they are looked at after the result
  task automatic fl(input logic [15:0] e);
    @(negedge aclk);
    `CHK(limit_flags, e)
    @(posedge aclk);
  endtask : fl
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] e;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(A_LO, 32'h0, RESP_OKAY);
    axi_rd(A_HI, 32'h0, RESP_OKAY);
    axi_rd(A_SU, 32'h0, RESP_OKAY);
    `CHK(alert_mode, MODE_RESET)
    detect_en <= 8'hff;
    conv(4'h8, 16'h7fff, 16'h8000, 16'h0010, 16'h0000);
    fl(16'h0000);
    // equal values are the boundary of both compares
    e = 16'h0000;
    for (int c = 8; c < 16; c++) begin
      conv(4'(c), 16'h8000 + 16'(c), 16'h8000 + 16'(c), 16'h0100, 16'h0000);
      e[2 * (c - 8)] = 1'b1;
      fl(e);
    end
    for (int c = 8; c < 16; c++) begin
      conv(4'(c), 16'h0200 + 16'(c), 16'hff00, 16'h0200 + 16'(c), 16'h0000);
      e[2 * (c - 8) + 1] = 1'b1;
      fl(e);
    end
    axi_wr(A_LO, 32'h0, RESP_OKAY);
    fl(16'hffff);
    axi_rd(A_LO, 32'hff, RESP_OKAY);
    fl(16'hff00);
    axi_rd(A_HI, 32'hff, RESP_OKAY);
    axi_rd(A_LO, 32'h0, RESP_OKAY);
    axi_rd(A_HI, 32'h0, RESP_OKAY);
    // ch8 disabled, ch1 outside this bank, ch9 enabled
    detect_en <= 8'hfe;
    conv(4'h8, 16'hffff, 16'h8000, 16'h0100, 16'h0000);
    conv(4'h8, 16'h0000, 16'h8000, 16'h0100, 16'h0000);
    conv(4'h1, 16'hffff, 16'h8000, 16'h0100, 16'h0000);
    conv(4'h9, 16'hffff, 16'h8000, 16'h0100, 16'h0000);
    fl(16'h0004);
    axi_rd(A_LO, 32'h04, RESP_OKAY);
    detect_en <= 8'hff;
    axi_rd(12'h004, 32'h0, RESP_SLVERR);
    axi_wr(12'h004, 32'hff, RESP_SLVERR);
    // band clear must stay off while the mode bit is 0
    conv(4'h9, 16'h0100, 16'h0100, 16'h0050, 16'h0010);
    conv(4'h9, 16'h00ef, 16'h0100, 16'h0050, 16'h0010);
    fl(16'h0004);
    axi_wr(A_SU, 32'h80, RESP_OKAY);
    axi_rd(A_SU, 32'h80, RESP_OKAY);
    `CHK(alert_mode, 1'b1)
    conv(4'h9, 16'h00f0, 16'h0100, 16'h0050, 16'h0010);
    fl(16'h0004);
    conv(4'h9, 16'h00ef, 16'h0100, 16'h0050, 16'h0010);
    fl(16'h0000);
    conv(4'h9, 16'h0050, 16'h0100, 16'h0050, 16'h0010);
    conv(4'h9, 16'h0060, 16'h0100, 16'h0050, 16'h0010);
    fl(16'h0008);
    conv(4'h9, 16'h0061, 16'h0100, 16'h0050, 16'h0010);
    fl(16'h0000);
    // a set at the very edge of the clearing read survives it
    res_chan <= 4'hc;
    res_data <= 16'hffff;
    upper_limit <= 16'h8000;
    res_valid <= 1'b1;
    axi_rd(A_HI, 32'h0, RESP_OKAY);
    fl(16'h0100);
    axi_rd(A_HI, 32'h01, RESP_OKAY);
    // a second reset in mid-run wipes flags and mode
    conv(4'h9, 16'hffff, 16'h8000, 16'h0050, 16'h0010);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fl(16'h0000);
    `CHK(alert_mode, MODE_RESET)
    end_sim();
  end
endmodule : taf_alert_flags_bench
